// ### rtl/odb_clock_divider_top.sv
// Functional notes
// - Multiple of 4, or divisor 2 outside bypass: 50% duty
// - Other even divisors give tabled lower duty
// - Inverted output duty is 100 minus duty
// - Thirty-two even divisors, 2 through 64
// - Equal divisors run in step after resync
// - Equal divisor and skew: identical edges
// - Inversion aligns edges of 50% outputs
// - Skew never exceeds 1 tick period
// - Bypass pin routes prescaler into dividers
// - Bypass halves divider ratios, 1 to 32
// - Bypass output: 2*fref/(M*V)
// - Bypass: no lock indication, no skew
// - Select low picks first pair, high second
// - Loop mode output ref_clk_i/Vk, prescaler and feedback only feed the match flag
// - Prescaler and feedback accept 1 to 32
`timescale 1ns/1ps
module odb_clock_divider_top (
  input  wire logic                          ref_clk_i,
  input  wire logic                          resetn_i,
  input  odb_pkg::odb_bus_req_t              bus_i,
  output logic [odb_pkg::DATA_W-1:0]         rdata_o,
  input  wire logic                          bypass_pin_i,
  input  wire logic                          reference_pair_select_i,
  input  wire logic                          reference_pair_first_i,
  input  wire logic                          reference_pair_second_i,
  output logic [odb_pkg::NUM_OUT-1:0]        clk_out_o,
  output logic                               fb_match_o
);
  import odb_pkg::*;

  // Synchronised pins
  logic bypass_s;
  logic reference_pair_select_s;
  logic ref_first_s;
  logic ref_second_s;

  odb_level_sync u_sync_bypass (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .d_i       (bypass_pin_i),
    .q_o       (bypass_s)
  );

  odb_level_sync u_sync_reference_pair_select (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .d_i       (reference_pair_select_i),
    .q_o       (reference_pair_select_s)
  );

  odb_level_sync u_sync_first (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .d_i       (reference_pair_first_i),
    .q_o       (ref_first_s)
  );

  odb_level_sync u_sync_second (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .d_i       (reference_pair_second_i),
    .q_o       (ref_second_s)
  );

  // Registers
  logic [2:0]         ctrl_reg;
  logic [4:0]         prescale_reg;
  logic [4:0]         feedback_reg;
  logic [NUM_OUT-1:0] invert_reg;
  logic [4:0]         div_reg  [NUM_OUT];
  logic [3:0]         skew_reg [NUM_OUT];

  // Prescaler, feedback and state
  logic               ref_prev_reg;
  logic [4:0]         pre_cnt_reg;
  logic               pre_tick_reg;
  logic [4:0]         fb_cnt_reg;
  logic               fb_prev_reg;
  logic               fb_tick_reg;
  logic               bypass_prev_reg;
  logic               resync_reg;

  // Address decode
  wire                wr        = bus_i.wr;
  wire  [7:0]         addr      = bus_i.addr;
  wire  [31:0]        wdata     = bus_i.wdata;
  wire                sel_ctrl  = (addr == OFS_CTRL);
  wire                sel_pre   = (addr == OFS_PRESCALE);
  wire                sel_fb    = (addr == OFS_FEEDBACK);
  wire                sel_inv   = (addr == OFS_INVERT);
  wire                sel_stat  = (addr == OFS_STATUS);
  wire                wr_ctrl   = wr && sel_ctrl;
  wire                wr_pre    = wr && sel_pre;
  wire                wr_fb     = wr && sel_fb;
  wire                wr_inv    = wr && sel_inv;
  wire  [7:0]         div_ofs   = addr - OFS_DIV_BASE;
  wire  [7:0]         skew_ofs  = addr - OFS_SKEW_BASE;
  wire                in_div    = (addr >= OFS_DIV_BASE) && (div_ofs[1:0] == 2'h0)
                                  && (div_ofs[7:2] < 6'(NUM_OUT));
  wire                in_skew   = (addr >= OFS_SKEW_BASE) && (skew_ofs[1:0] == 2'h0)
                                  && (skew_ofs[7:2] < 6'(NUM_OUT));
  wire  [2:0]         div_idx   = div_ofs[4:2];
  wire  [2:0]         skew_idx  = skew_ofs[4:2];

  // Reference pair choice and prescaler
  wire                ref_sel   = reference_pair_select_s ? ref_second_s : ref_first_s;
  wire                ref_rise  = ref_sel && !ref_prev_reg;
  wire                pre_wrap  = ref_rise && (pre_cnt_reg == prescale_reg);

  // Dividers step every clock in loop mode, on prescaler ticks in bypass
  wire                div_tick  = bypass_s ? pre_tick_reg : 1'b1;
  wire  [2:0]         fb_sel    = ctrl_reg[CTRL_FB_SEL_LSB +: 3];
  wire  [2:0]         fb_idx    = (fb_sel < 3'(NUM_OUT)) ? fb_sel : 3'h0;
  wire                fb_level  = clk_out_o[fb_idx];
  wire                fb_rise   = fb_level && !fb_prev_reg;
  wire                fb_wrap   = fb_rise && (fb_cnt_reg == feedback_reg);
  // A prescaler or divider write, or a bypass change, restarts all dividers together
  wire                ratio_write = wr_pre || (wr && in_div);
  wire                bypass_flip = (bypass_s != bypass_prev_reg);
  wire                resync_next = ratio_write || bypass_flip;

  odb_out_cfg_t       out_cfg [NUM_OUT];

  genvar k;
  generate
    for (k = 0; k < NUM_OUT; k++)
    begin : g_out
      // Write enables of this output
      wire wr_div_k  = wr && in_div && (div_idx == 3'(k));
      wire wr_skew_k = wr && in_skew && (skew_idx == 3'(k));

      assign out_cfg[k] = '{div_code: div_reg[k], inv: invert_reg[k], skew: skew_reg[k]};

      always_ff @(posedge ref_clk_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          div_reg[k]  <= DIV_RST;
          skew_reg[k] <= SKEW_RST;
        end
        else
        begin
          if (wr_div_k)
            div_reg[k] <= wdata[4:0];
          if (wr_skew_k)
            skew_reg[k] <= wdata[3:0];
        end
      end

      odb_out_divider u_div (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .tick_i    (div_tick),
        .resync_i  (resync_reg),
        .bypass_i  (bypass_s),
        .cfg_i     (out_cfg[k]),
        .clk_o     (clk_out_o[k])
      );
    end
  endgenerate

  // Feedback output select
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      ctrl_reg <= CTRL_RST;
    else if (wr_ctrl)
      ctrl_reg <= wdata[2:0];
  end

  // Prescaler setting, holds M-1
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      prescale_reg <= PRESCALE_RST;
    else if (wr_pre)
      prescale_reg <= wdata[4:0];
  end

  // Feedback setting, holds N-1
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      feedback_reg <= FEEDBACK_RST;
    else if (wr_fb)
      feedback_reg <= wdata[4:0];
  end

  // Per-output inversion
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      invert_reg <= '0;
    else if (wr_inv)
      invert_reg <= wdata[NUM_OUT-1:0];
  end

  // Next counts of prescaler and feedback divider
  wire  [4:0]         pre_cnt_next = (wr_pre || pre_wrap) ? 5'h00
                                   : (ref_rise ? pre_cnt_reg + 5'h01 : pre_cnt_reg);
  wire  [4:0]         fb_cnt_next  = (wr_fb || fb_wrap) ? 5'h00
                                   : (fb_rise ? fb_cnt_reg + 5'h01 : fb_cnt_reg);

  // Prescaler on the chosen reference
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ref_prev_reg <= 1'b0;
      pre_cnt_reg  <= 5'h00;
      pre_tick_reg <= 1'b0;
    end
    else
    begin
      ref_prev_reg <= ref_sel;
      pre_cnt_reg  <= pre_cnt_next;
      pre_tick_reg <= pre_wrap;
    end
  end

  // Feedback divider on the selected output
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      fb_prev_reg <= 1'b0;
      fb_cnt_reg  <= 5'h00;
      fb_tick_reg <= 1'b0;
    end
    else
    begin
      fb_prev_reg <= fb_level;
      fb_cnt_reg  <= fb_cnt_next;
      fb_tick_reg <= fb_wrap;
    end
  end

  // Restart request, one cycle after its cause
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      bypass_prev_reg <= 1'b0;
      resync_reg      <= 1'b0;
    end
    else
    begin
      bypass_prev_reg <= bypass_s;
      resync_reg      <= resync_next;
    end
  end

  // Coincidence flag, held low in bypass
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      fb_match_o <= 1'b0;
    else
      fb_match_o <= !bypass_s && pre_tick_reg && fb_tick_reg;
  end

  // Read data
  logic [31:0] status_word;
  logic [31:0] rd_mux;

  // Status word: pin states, match flag, output levels
  always_comb
  begin
    status_word                          = '0;
    status_word[STAT_BYPASS]             = bypass_s;
    status_word[STAT_REFERENCE_PAIR_SELECT]             = reference_pair_select_s;
    status_word[STAT_FB_MATCH]           = fb_match_o;
    status_word[STAT_OUT_LSB +: NUM_OUT] = clk_out_o;
  end

  always_comb
  begin
    rd_mux = UNMAPPED_DATA;
    if (sel_ctrl)
      rd_mux = {29'h0, ctrl_reg};
    else if (sel_pre)
      rd_mux = {27'h0, prescale_reg};
    else if (sel_fb)
      rd_mux = {27'h0, feedback_reg};
    else if (sel_inv)
      rd_mux = {27'h0, invert_reg};
    else if (sel_stat)
      rd_mux = status_word;
    else if (in_div)
      rd_mux = {27'h0, div_reg[div_idx]};
    else if (in_skew)
      rd_mux = {28'h0, skew_reg[skew_idx]};
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rdata_o <= UNMAPPED_DATA;
    else if (bus_i.rd)
      rdata_o <= rd_mux;
    else
      rdata_o <= UNMAPPED_DATA;
  end
endmodule // odb_clock_divider_top

// ### rtl/odb_pkg.sv
package odb_pkg;

  localparam int          NUM_OUT        = 5;
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;

  // Clock and time base
  localparam int          REF_CLK_HZ     = 25000000;
  localparam int          SKEW_STEPS     = 16;
  localparam int          SKEW_EIGHTHS   = 15;
  // Largest skew in eighths of a tick, whole ticks rounded down
  localparam int          SKEW_MAX_TICKS = SKEW_EIGHTHS / 8;

  // Register offsets (byte addresses)
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_PRESCALE   = 8'h04;
  localparam logic [7:0]  OFS_FEEDBACK   = 8'h08;
  localparam logic [7:0]  OFS_INVERT     = 8'h0c;
  localparam logic [7:0]  OFS_STATUS     = 8'h10;
  localparam logic [7:0]  OFS_DIV_BASE   = 8'h20;
  localparam logic [7:0]  OFS_SKEW_BASE  = 8'h40;

  // Field positions
  localparam int          CTRL_FB_SEL_LSB = 0;
  localparam int          STAT_BYPASS     = 0;
  localparam int          STAT_REFERENCE_PAIR_SELECT     = 1;
  localparam int          STAT_FB_MATCH   = 2;
  localparam int          STAT_OUT_LSB    = 8;

  // Reset values
  localparam logic [2:0]  CTRL_RST       = 3'h0;
  localparam logic [4:0]  PRESCALE_RST   = 5'h00;
  localparam logic [4:0]  FEEDBACK_RST   = 5'h00;
  localparam logic [4:0]  DIV_RST        = 5'h00;
  localparam logic [3:0]  SKEW_RST       = 4'h0;
  localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } odb_bus_req_t;

  // Code k selects divisor 2*(k+1)
  typedef struct packed {
    logic [4:0] div_code;
    logic       inv;
    logic [3:0] skew;
  } odb_out_cfg_t;

endpackage

// ### rtl/odb_level_sync.sv
`timescale 1ns/1ps
module odb_level_sync (
  input  wire logic ref_clk_i,
  input  wire logic resetn_i,
  input  wire logic d_i,
  output logic      q_o
);
  import odb_pkg::*;

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // Change accepted once stages two and three agree
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      q_o    <= 1'b0;
    end
    else
    begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        q_o <= s3_reg;
    end
  end
endmodule // odb_level_sync

// ### rtl/odb_out_divider.sv
`timescale 1ns/1ps
module odb_out_divider (
  input  wire logic          ref_clk_i,
  input  wire logic          resetn_i,
  input  wire logic          tick_i,
  input  wire logic          resync_i,
  input  wire logic          bypass_i,
  input  odb_pkg::odb_out_cfg_t cfg_i,
  output logic               clk_o
);
  import odb_pkg::*;

  logic [6:0] cnt_reg;
  logic       dly_reg;

  wire  [6:0] div_v      = {1'b0, cfg_i.div_code, 1'b0} + 7'h02;
  // Halved ratio while bypassed
  wire  [6:0] period     = bypass_i ? {1'b0, div_v[6:1]} : div_v;
  wire        even_half  = (div_v[1:0] == 2'h0) || (div_v == 7'h02);
  // Half high for 2 and multiples of 4, else (V-2)/2 high
  wire  [6:0] hi_norm    = even_half ? {1'b0, div_v[6:1]}
                                     : {1'b0, div_v[6:1]} - 7'h01;
  wire  [6:0] hi_byp     = {2'h0, div_v[6:2]};
  wire  [6:0] hi_time    = bypass_i ? hi_byp : hi_norm;
  wire  [6:0] last_cnt   = period - 7'h01;
  wire  [6:0] cnt_next   = (cnt_reg >= last_cnt) ? 7'h00 : cnt_reg + 7'h01;
  wire        level      = cnt_reg < hi_time;
  wire        pre_skew   = level ^ cfg_i.inv;
  // Skew rounded to whole ticks, none in bypass
  wire        use_dly    = !bypass_i && (cfg_i.skew >= 4'(8 * SKEW_MAX_TICKS));
  wire        skewed     = use_dly ? dly_reg : pre_skew;

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cnt_reg <= 7'h00;
      dly_reg <= 1'b0;
      clk_o   <= 1'b0;
    end
    else
    begin
      if (resync_i)
        cnt_reg <= 7'h00;
      else if (tick_i)
        cnt_reg <= cnt_next;
      dly_reg <= pre_skew;
      clk_o   <= skewed;
    end
  end
endmodule // odb_out_divider

// ### testbench/odb_clock_divider_props.sv
`timescale 1ns/1ps
module odb_clock_divider_props
  import odb_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  resetn_i,
  input  odb_pkg::odb_bus_req_t      bus_i,
  input  wire logic [DATA_W-1:0]     rdata_o,
  input  wire logic                  bypass_pin_i,
  input  wire logic                  reference_pair_select_i,
  input  wire logic                  reference_pair_first_i,
  input  wire logic                  reference_pair_second_i,
  input  wire logic [NUM_OUT-1:0]    clk_out_o,
  input  wire logic                  fb_match_o
);
  wire       wr = bus_i.wr;
  wire       rd = bus_i.rd;
  wire [7:0] ad = bus_i.addr;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  property p_pre_rw;
    wr && ad == OFS_PRESCALE ##1 rd && ad == OFS_PRESCALE
      |=> rdata_o == {27'h0, $past(bus_i.wdata[4:0], 2)};
  endproperty
  a_pre_rw: assert property (p_pre_rw) else $error("prescale readback");
  property p_fb_rw;
    wr && ad == OFS_FEEDBACK ##1 rd && ad == OFS_FEEDBACK
      |=> rdata_o == {27'h0, $past(bus_i.wdata[4:0], 2)};
  endproperty
  a_fb_rw: assert property (p_fb_rw) else $error("feedback readback");
  property p_div_rw;
    wr && ad == OFS_DIV_BASE ##1 rd && ad == OFS_DIV_BASE
      |=> rdata_o == {27'h0, $past(bus_i.wdata[4:0], 2)};
  endproperty
  a_div_rw: assert property (p_div_rw) else $error("divider readback");
  property p_inv_rw;
    wr && ad == OFS_INVERT ##1 rd && ad == OFS_INVERT
      |=> rdata_o == {27'h0, $past(bus_i.wdata[4:0], 2)};
  endproperty
  a_inv_rw: assert property (p_inv_rw) else $error("invert readback");
  property p_rd_idle;
    !rd |=> rdata_o == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
  property p_byp_nofb;
    bypass_pin_i [*8] |-> !fb_match_o;
  endproperty
  a_byp_nofb: assert property (p_byp_nofb) else $error("match flag in bypass");
  property p_stat_sel;
    $stable(reference_pair_select_i) [*6] ##0 (rd && ad == OFS_STATUS)
      |=> rdata_o[STAT_REFERENCE_PAIR_SELECT] == $past(reference_pair_select_i);
  endproperty
  a_stat_sel: assert property (p_stat_sel) else $error("select status");
  property p_stat_byp;
    $stable(bypass_pin_i) [*6] ##0 (rd && ad == OFS_STATUS)
      |=> rdata_o[STAT_BYPASS] == $past(bypass_pin_i);
  endproperty
  a_stat_byp: assert property (p_stat_byp) else $error("bypass status");
  c_byp: cover property (bypass_pin_i [*8] ##1 $rose(clk_out_o[0]));
  c_out1: cover property ($rose(clk_out_o[1]));
  c_fb: cover property (fb_match_o);
endmodule // odb_clock_divider_props

// ### testbench/odb_ref_source.sv
`timescale 1ns/1ps
module odb_ref_source #(
  parameter int HALF_A = 4,
  parameter int HALF_B = 6
) (
  input  wire logic ref_clk_i,
  output logic      reference_pair_first_o,
  output logic      reference_pair_second_o
);
  int cnt_a = 0;
  int cnt_b = 0;
  initial reference_pair_first_o = 1'b0;
  initial reference_pair_second_o = 1'b0;
  // Two free-running sources at different rates
  always @(posedge ref_clk_i)
  begin
    cnt_a <= (cnt_a == HALF_A - 1) ? 0 : cnt_a + 1;
    cnt_b <= (cnt_b == HALF_B - 1) ? 0 : cnt_b + 1;
    if (cnt_a == HALF_A - 1)
      reference_pair_first_o <= ~reference_pair_first_o;
    if (cnt_b == HALF_B - 1)
      reference_pair_second_o <= ~reference_pair_second_o;
  end
endmodule // odb_ref_source

// ### testbench/odb_clock_divider_top_tb.sv
`timescale 1ns/1ps
module odb_clock_divider_top_tb;
  import odb_pkg::*;
  localparam int PA = 8;
  localparam int PB = 12;
  logic               ref_clk_i = 1'b0;
  logic               resetn_i = 1'b0;
  odb_bus_req_t       bus = '0;
  logic [DATA_W-1:0]  rdata;
  logic               byp = 1'b0;
  logic               sel = 1'b0;
  wire                ra;
  wire                rb;
  logic [NUM_OUT-1:0] co;
  logic               fbm;
  logic [31:0]        d;
  int                 fails = 0;
  int                 n_checks = 0;
  int                 hi;
  int                 lo;
  int                 v;
  always #20 ref_clk_i = ~ref_clk_i;
  odb_ref_source #(.HALF_A(PA / 2), .HALF_B(PB / 2)) src (
    .ref_clk_i(ref_clk_i), .reference_pair_first_o(ra), .reference_pair_second_o(rb));
  odb_clock_divider_top dut (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .bus_i(bus), .rdata_o(rdata),
    .bypass_pin_i(byp), .reference_pair_select_i(sel), .reference_pair_first_i(ra),
    .reference_pair_second_i(rb), .clk_out_o(co), .fb_match_o(fbm));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    @(posedge ref_clk_i);
    bus <= '{1'b1, 1'b0, a, x};
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    @(posedge ref_clk_i);
    bus <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge ref_clk_i);
    bus <= '0;
    #1 x = rdata;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_i) bus <= '0;
  endtask
  task automatic step(inout int c);
    @(posedge ref_clk_i);
    #1 c++;
  endtask
  // High and low run lengths of one full period
  task automatic meas(input int k, output int h, output int l);
    int t;
    t = 0;
    h = 0;
    l = 0;
    while (co[k] !== 1'b0 && t < 300) step(t);
    while (co[k] !== 1'b1 && t < 600) step(t);
    while (co[k] === 1'b1 && h < 300) step(h);
    while (co[k] === 1'b0 && l < 300) step(l);
  endtask
  function automatic int exp_hi(input int vv);
    return (vv == 2 || vv % 4 == 0) ? vv / 2 : (vv - 2) / 2;
  endfunction
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #2_000_000;
    fails++;
    complete_run;
  end
  initial
  begin
    repeat (5) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    rd(OFS_DIV_BASE, d);
    chk(d, {27'h0, DIV_RST});
    rd(8'h3c, d);
    chk(d, UNMAPPED_DATA);
    wr(OFS_PRESCALE, 32'hffff_ffff);
    rd(OFS_PRESCALE, d);
    chk(d, 32'h0000_001f);
    wr(OFS_FEEDBACK, 32'hffff_ffe0);
    rd(OFS_FEEDBACK, d);
    chk(d, 32'h0);
    for (int c = 0; c < 32; c++)
      for (int i = 0; i < 2; i++)
      begin
        v = 2 * (c + 1);
        wr(OFS_INVERT, i);
        wr(OFS_DIV_BASE, c);
        rd(OFS_DIV_BASE, d);
        chk(d, c);
        meas(0, hi, lo);
        chk(hi, i ? v - exp_hi(v) : exp_hi(v));
        chk(hi + lo, v);
      end
    wr(OFS_INVERT, 32'h1f);
    rd(OFS_INVERT, d);
    chk(d, 32'h1f);
    wr(OFS_CTRL, 32'h7);
    rd(OFS_CTRL, d);
    chk(d, 32'h7);
    wr(OFS_INVERT, 32'h2);
    wr(OFS_DIV_BASE, 1);
    wr(OFS_DIV_BASE + 8'h04, 3);
    idle(8);
    repeat (32)
    begin
      #1 d[1:0] = co[1:0];
      @(posedge ref_clk_i);
      #1 if (co[1] && !d[1]) chk(co[0] && !d[0], 1'b1);
    end
    wr(OFS_INVERT, 0);
    wr(OFS_DIV_BASE, 2);
    wr(OFS_DIV_BASE + 8'h04, 2);
    idle(8);
    repeat (24) @(posedge ref_clk_i) #1 chk(co[1], co[0]);
    for (int s = 7; s < 16; s += 8)
    begin
      wr(OFS_SKEW_BASE + 8'h04, s);
      idle(8);
      repeat (24)
      begin
        #1 d[0] = co[0];
        @(posedge ref_clk_i);
        #1 chk(co[1], s >= 8 ? d[0] : co[0]);
      end
    end
    rd(OFS_SKEW_BASE + 8'h04, d);
    chk(d, 32'h0000_000f);
    for (int k = 0; k < NUM_OUT; k++)
      wr(OFS_DIV_BASE + 8'(4 * k), 1);
    for (int m = 1; m <= 2; m++)
      for (int s = 0; s < 2; s++)
      begin
        wr(OFS_PRESCALE, m - 1);
        sel <= s[0];
        byp <= 1'b1;
        idle(60);
        rd(OFS_STATUS, d);
        chk(d[STAT_BYPASS], 1'b1);
        chk(d[STAT_REFERENCE_PAIR_SELECT], s);
        chk(d[STAT_FB_MATCH], 1'b0);
        meas(0, hi, lo);
        chk(hi + lo, (s ? PB : PA) * m * 2);
        chk(hi, lo);
        chk(co[1], co[0]);
        chk(fbm, 1'b0);
      end
    complete_run;
  end
endmodule // odb_clock_divider_top_tb
bind odb_clock_divider_top odb_clock_divider_props u_props (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .bypass_pin_i(bypass_pin_i), .reference_pair_select_i(reference_pair_select_i),
  .reference_pair_first_i(reference_pair_first_i),
  .reference_pair_second_i(reference_pair_second_i), .clk_out_o(clk_out_o),
  .fb_match_o(fb_match_o));
